// file: verilog/rmsp_reset_mode.v
// reset stretcher, cause recorder, mode select and single-wire debug pin handling
//
// Contract
// - any reset start pulls the reset pin low for 66 bus cycles.
// - record which source caused each reset in the cause register.
// - reset pin is open drain: only driven low, pull-up returns it high.
// - during power-on or forced debug reset the mode pin is a mode input; the code releases a debug link drive one cycle after the reset starts.
// - once reset ends the mode pin belongs to the serial debug link.
// - mode pin high at reset release after power-on or forced reset: run mode.
// - host holding mode pin low then forces active background mode.
// - external pin reset always leads to user run mode; the code reads the mode pin if a forced or power-on reset coincides.
// - forced debug reset bit written with mode pin low enters background mode.
// - each debug link bit time lasts 16 debug clock cycles.
// - debug pin is pseudo open drain with a brief high speedup pulse.
// - after reset the clock source is the internal clock generator.
// - after reset every port pin is a high-impedance input, no pull-up.
// - in active background mode the processor stays suspended.
`include "rmsp_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rmsp_reset_mode #(
  parameter PORT_W = 16
) (
  input  wire                     sys_clk,
  input  wire                     rst_n,
  input  wire                     por_evt,
  input  wire                     int_rst_evt,
  input  wire                     force_debug_reset_bit,
  input  wire                     reset_pin_in,
  output reg                      reset_pin_out_ff,
  output reg                      reset_pin_oe_n_ff,
  input  wire                     debug_mode_select_pin_in,
  output reg                      debug_mode_select_pin_out_ff,
  output reg                      debug_mode_select_pin_oe_n_ff,
  input  wire                     dbg_tx_req,
  input  wire                     dbg_tx_bit,
  output reg                      dbg_tx_done_ff,
  output reg                      dbg_rx_valid_ff,
  output reg                      dbg_rx_bit_ff,
  output reg                      internal_reset_ff,
  output reg  [`RMSP_CAUSE_W-1:0] reset_cause_reg_ff,
  output reg                      background_debug_state_ff,
  output reg                      cpu_suspend_ff,
  output reg                      clk_sel_ext_ff,
  output reg  [PORT_W-1:0]        port_dir_out_ff,
  output reg  [PORT_W-1:0]        port_pullup_en_ff
);

  // three-stage synchronisers for both pins
  reg  [2:0] rpin_sync_ff;
  reg  [2:0] mpin_sync_ff;
  reg        rpin_low_ff;
  reg        mpin_lvl_ff;
  reg  [`RMSP_STRETCH_W-1:0] stretch_cnt_ff;
  reg        stretching_ff;
  reg        mode_src_ff;
  reg  [4:0] bit_cnt_ff;
  reg        tx_busy_ff;
  reg        tx_bit_ff;
  reg        rx_busy_ff;
  reg        mpin_prev_ff;
  reg        echo_ff;
  wire       ext_req;
  wire       any_start;
  wire       mode_capable;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rpin_sync_ff <= 3'h7;
      mpin_sync_ff <= 3'h7;
      rpin_low_ff  <= 1'b0;
      mpin_lvl_ff  <= 1'b1;
    end else begin
      rpin_sync_ff <= {rpin_sync_ff[1:0], reset_pin_in};
      mpin_sync_ff <= {mpin_sync_ff[1:0], debug_mode_select_pin_in};
      // change counts only once stages two and three agree
      if (rpin_sync_ff[1] == rpin_sync_ff[2])
        rpin_low_ff <= ~rpin_sync_ff[2];
      if (mpin_sync_ff[1] == mpin_sync_ff[2])
        mpin_lvl_ff <= mpin_sync_ff[2];
    end
  end

  // self-drive masked
  // own drive echoes back through the synchroniser, so ignore it while stretching
  // the released pin needs a few cycles to read back high, so the echo is masked until then
  // limitation: a press still held after the stretch is not taken twice
  assign ext_req   = rpin_low_ff & ~stretching_ff & ~internal_reset_ff & ~echo_ff;
  assign any_start = por_evt | int_rst_evt | force_debug_reset_bit | ext_req;
  assign mode_capable = por_evt | force_debug_reset_bit;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      stretch_cnt_ff     <= `RMSP_STRETCH_CYC;
      stretching_ff      <= 1'b1;
      internal_reset_ff  <= 1'b1;
      reset_cause_reg_ff <= `RMSP_CAUSE_RST;
      mode_src_ff        <= 1'b1;
      reset_pin_out_ff   <= 1'b0;
      reset_pin_oe_n_ff  <= 1'b0;
      echo_ff            <= 1'b1;
    end else begin
      reset_pin_out_ff <= 1'b0;
      if (stretching_ff)
        echo_ff <= 1'b1;
      else if (!rpin_low_ff)
        echo_ff <= 1'b0;
      if (any_start && !stretching_ff) begin
        stretch_cnt_ff    <= `RMSP_STRETCH_CYC;
        stretching_ff     <= 1'b1;
        internal_reset_ff <= 1'b1;
        reset_pin_oe_n_ff <= 1'b0;
        reset_cause_reg_ff <= {force_debug_reset_bit, int_rst_evt, ext_req & ~por_evt, por_evt};
        mode_src_ff <= mode_capable;
      end else if (stretching_ff) begin
        if (stretch_cnt_ff == `RMSP_STRETCH_W'd1) begin
          stretching_ff     <= 1'b0;
          internal_reset_ff <= 1'b0;
          reset_pin_oe_n_ff <= 1'b1;
        end
        stretch_cnt_ff <= stretch_cnt_ff - `RMSP_STRETCH_W'd1;
      end
    end
  end

  // mode decision at the falling edge of internal reset
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      background_debug_state_ff <= `RMSP_MODE_RUN;
      cpu_suspend_ff            <= 1'b1;
      clk_sel_ext_ff            <= `RMSP_CLK_INTERNAL;
      port_dir_out_ff           <= {PORT_W{1'b0}};
      port_pullup_en_ff         <= {PORT_W{1'b0}};
    end else if (any_start && !stretching_ff) begin
      // suspend with reset start, not a cycle later
      cpu_suspend_ff <= 1'b1;
    end else if (internal_reset_ff) begin
      cpu_suspend_ff    <= 1'b1;
      clk_sel_ext_ff    <= `RMSP_CLK_INTERNAL;
      port_dir_out_ff   <= {PORT_W{1'b0}};
      port_pullup_en_ff <= {PORT_W{1'b0}};
      if (stretch_cnt_ff == `RMSP_STRETCH_W'd1) begin
        background_debug_state_ff <= (mode_src_ff && !mpin_lvl_ff) ? `RMSP_MODE_BGND : `RMSP_MODE_RUN;
        cpu_suspend_ff            <= mode_src_ff && !mpin_lvl_ff;
      end
    end
  end

  // debug link on the mode pin after reset
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      debug_mode_select_pin_out_ff  <= 1'b0;
      debug_mode_select_pin_oe_n_ff <= 1'b1;
      bit_cnt_ff      <= 5'h00;
      tx_busy_ff      <= 1'b0;
      tx_bit_ff       <= 1'b0;
      rx_busy_ff      <= 1'b0;
      mpin_prev_ff    <= 1'b1;
      dbg_tx_done_ff  <= 1'b0;
      dbg_rx_valid_ff <= 1'b0;
      dbg_rx_bit_ff   <= 1'b0;
    end else begin
      dbg_tx_done_ff  <= 1'b0;
      dbg_rx_valid_ff <= 1'b0;
      mpin_prev_ff    <= mpin_lvl_ff;
      if (internal_reset_ff) begin
        debug_mode_select_pin_oe_n_ff <= 1'b1;
        tx_busy_ff <= 1'b0;
        rx_busy_ff <= 1'b0;
        bit_cnt_ff <= 5'h00;
      end else if (tx_busy_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff == 5'h00) begin
          debug_mode_select_pin_out_ff  <= 1'b0;
          debug_mode_select_pin_oe_n_ff <= 1'b0;
        end else if (bit_cnt_ff == `RMSP_SPEEDUP_CYC + (tx_bit_ff ? 5'h00 : `RMSP_SAMPLE_CYC)) begin
          debug_mode_select_pin_out_ff  <= 1'b1;
          debug_mode_select_pin_oe_n_ff <= 1'b0;
        end else if (debug_mode_select_pin_out_ff) begin
          debug_mode_select_pin_oe_n_ff <= 1'b1;
          debug_mode_select_pin_out_ff  <= 1'b0;
        end
        if (bit_cnt_ff == `RMSP_BIT_CYC - 5'h01) begin
          tx_busy_ff     <= 1'b0;
          dbg_tx_done_ff <= 1'b1;
        end
      end else if (rx_busy_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff == `RMSP_SAMPLE_CYC) begin
          dbg_rx_bit_ff   <= mpin_lvl_ff;
          dbg_rx_valid_ff <= 1'b1;
        end
        if (bit_cnt_ff == `RMSP_BIT_CYC - 5'h01)
          rx_busy_ff <= 1'b0;
      end else if (dbg_tx_req) begin
        tx_busy_ff <= 1'b1;
        tx_bit_ff  <= dbg_tx_bit;
        bit_cnt_ff <= 5'h00;
      end else if (mpin_prev_ff && !mpin_lvl_ff) begin
        // host falling edge starts a received bit
        rx_busy_ff <= 1'b1;
        bit_cnt_ff <= 5'h01;
      end
    end
  end

endmodule // rmsp_reset_mode

`default_nettype wire

// file: shared/rmsp_defines.vh
// constants for the reset and mode select pin block
`ifndef RMSP_DEFINES_VH
`define RMSP_DEFINES_VH
`define RMSP_STRETCH_CYC      7'd66
`define RMSP_STRETCH_W        7
`define RMSP_BIT_CYC          5'd16
`define RMSP_SPEEDUP_CYC      5'd1
`define RMSP_SAMPLE_CYC       5'd8
`define RMSP_CAUSE_W          4
`define RMSP_CAUSE_POR        0
`define RMSP_CAUSE_PIN        1
`define RMSP_CAUSE_INT        2
`define RMSP_CAUSE_DBG        3
`define RMSP_CAUSE_RST        4'h0
`define RMSP_MODE_RUN         1'b0
`define RMSP_MODE_BGND        1'b1
`define RMSP_CLK_INTERNAL     1'b0
`endif

// file: verification/rmsp_reset_mode_asserts.sv
// assertion checker for the reset and mode pin block
`timescale 1ns/1ps
`default_nettype none
`include "rmsp_defines.vh"
module rmsp_reset_mode_asserts #(
  parameter PORT_W = 16
) (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     reset_pin_out_ff,
  input wire logic                     reset_pin_oe_n_ff,
  input wire logic                     debug_mode_select_pin_out_ff,
  input wire logic                     debug_mode_select_pin_oe_n_ff,
  input wire logic                     dbg_tx_done_ff,
  input wire logic                     dbg_rx_valid_ff,
  input wire logic                     internal_reset_ff,
  input wire logic [`RMSP_CAUSE_W-1:0] reset_cause_reg_ff,
  input wire logic                     background_debug_state_ff,
  input wire logic                     cpu_suspend_ff,
  input wire logic                     clk_sel_ext_ff,
  input wire logic [PORT_W-1:0]        port_dir_out_ff,
  input wire logic [PORT_W-1:0]        port_pullup_en_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  stretch_len_a: assert property ($fell(reset_pin_oe_n_ff) |-> ##66 $rose(reset_pin_oe_n_ff))
    else $error("reset stretch length wrong");
  pin_pair_a: assert property (internal_reset_ff == !reset_pin_oe_n_ff)
    else $error("pin drive and internal reset differ");
  drive_low_a: assert property (reset_pin_out_ff == 1'b0)
    else $error("reset pin driven high");
  mode_in_a: assert property (internal_reset_ff |-> debug_mode_select_pin_oe_n_ff)
    else $error("mode pin driven during reset");
  cause_hold_a: assert property (!internal_reset_ff && !$past(internal_reset_ff) |->
    $stable(reset_cause_reg_ff) && $stable(background_debug_state_ff)) else $error("cause or mode moved");
  pin_run_a: assert property (!internal_reset_ff && reset_cause_reg_ff[`RMSP_CAUSE_PIN] |->
    !background_debug_state_ff) else $error("pin reset gave background mode");
  suspend_a: assert property (internal_reset_ff || background_debug_state_ff |-> cpu_suspend_ff)
    else $error("processor not suspended");
  defaults_a: assert property ($fell(internal_reset_ff) |-> !clk_sel_ext_ff &&
    port_dir_out_ff == '0 && port_pullup_en_ff == '0) else $error("reset defaults wrong");
  speedup_a: assert property (!debug_mode_select_pin_oe_n_ff && debug_mode_select_pin_out_ff |=>
    debug_mode_select_pin_oe_n_ff) else $error("speedup pulse too long");
  bit_time_a: assert property ($fell(debug_mode_select_pin_oe_n_ff) |-> ##[13:15] dbg_tx_done_ff)
    else $error("bit slot length wrong");
  cover property ($fell(internal_reset_ff) && background_debug_state_ff);
  cover property (dbg_rx_valid_ff);
  cover property (dbg_tx_done_ff);
endmodule // rmsp_reset_mode_asserts
`default_nettype wire

// file: verification/rmsp_host_model.sv
// debug host and reset switch model
`timescale 1ns/1ps
`default_nettype none
module rmsp_host_model (
  input  wire logic sys_clk,
  input  wire logic reset_pin_oe_n_ff,
  input  wire logic debug_mode_select_pin_out_ff,
  input  wire logic debug_mode_select_pin_oe_n_ff,
  output wire logic reset_pin_in,
  output wire logic debug_mode_select_pin_in
);
  logic press = 1'b0;
  logic drv   = 1'b0;
  logic val   = 1'b1;
  assign reset_pin_in = !(press || !reset_pin_oe_n_ff);
  assign debug_mode_select_pin_in = !debug_mode_select_pin_oe_n_ff ? debug_mode_select_pin_out_ff : (drv ? val : 1'b1);
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic hold_ms(input logic low);
    drv = low;
    val = !low;
  endtask
  task automatic push(input int n);
    press = 1'b1;
    repeat (n) tick;
    press = 1'b0;
  endtask
  task automatic send_bit(input logic b);
    drv = 1'b1;
    val = 1'b0;
    repeat (b ? 4 : 13) tick;
    val = 1'b1;
    tick;
    drv = 1'b0;
    repeat (b ? 11 : 2) tick;
  endtask
  task automatic read_bit(output logic b);
    for (int i = 0; i < 40 && debug_mode_select_pin_in !== 1'b0; i++) tick;
    repeat (4) tick;
    b = debug_mode_select_pin_in;
    repeat (12) tick;
  endtask
endmodule // rmsp_host_model
`default_nettype wire

// file: verification/rmsp_reset_mode_tb_top.sv
// testbench for the reset and mode pin block
`timescale 1ns/1ps
`default_nettype none
module rmsp_reset_mode_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, por_evt = 1'b0, int_rst_evt = 1'b0, force_debug_reset_bit = 1'b0;
  logic dbg_tx_req = 1'b0, dbg_tx_bit = 1'b0, rx_got = 1'b0;
  wire logic reset_pin_in, reset_pin_out_ff, reset_pin_oe_n_ff, debug_mode_select_pin_in, dbg_tx_done_ff;
  wire logic debug_mode_select_pin_out_ff, debug_mode_select_pin_oe_n_ff, dbg_rx_valid_ff, dbg_rx_bit_ff;
  wire logic internal_reset_ff, background_debug_state_ff, cpu_suspend_ff, clk_sel_ext_ff;
  wire logic [3:0] reset_cause_reg_ff;
  wire logic [15:0] port_dir_out_ff, port_pullup_en_ff;
  int n_mismatch = 0, cmp_count = 0, n_done = 0, n0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (dbg_rx_valid_ff) rx_got <= dbg_rx_bit_ff;
    if (dbg_tx_done_ff) n_done <= n_done + 1;
  end
  rmsp_reset_mode #(.PORT_W(16)) rmsp_reset_mode_inst (.sys_clk, .rst_n, .por_evt, .int_rst_evt,
    .force_debug_reset_bit, .reset_pin_in, .reset_pin_out_ff, .reset_pin_oe_n_ff, .debug_mode_select_pin_in,
    .debug_mode_select_pin_out_ff, .debug_mode_select_pin_oe_n_ff, .dbg_tx_req, .dbg_tx_bit, .dbg_tx_done_ff,
    .dbg_rx_valid_ff, .dbg_rx_bit_ff, .internal_reset_ff, .reset_cause_reg_ff, .background_debug_state_ff,
    .cpu_suspend_ff, .clk_sel_ext_ff, .port_dir_out_ff, .port_pullup_en_ff);
  rmsp_host_model rmsp_host_model_inst (.sys_clk, .reset_pin_oe_n_ff, .debug_mode_select_pin_out_ff,
    .debug_mode_select_pin_oe_n_ff, .reset_pin_in, .debug_mode_select_pin_in);
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // counts stretch cycles; a stuck stretch ends the run
  task automatic run_out(output int n);
    for (n = 0; internal_reset_ff !== 1'b0; n++) begin
      tick;
      if (n > 300) begin
        n_mismatch++;
        wrap_up;
      end
    end
  endtask
  task automatic settle(input logic [3:0] cause, input logic bg);
    chk(reset_cause_reg_ff, cause);
    chk({clk_sel_ext_ff, background_debug_state_ff, cpu_suspend_ff}, {1'b0, bg, bg});
    chk(port_dir_out_ff | port_pullup_en_ff, 16'h0000);
    chk(debug_mode_select_pin_oe_n_ff, 1'b1);
    rmsp_host_model_inst.hold_ms(1'b0);
    repeat (8) tick;
  endtask
  task automatic do_reset(input int src, input logic ms_low, input logic [3:0] cause, input logic bg);
    int n;
    rmsp_host_model_inst.hold_ms(ms_low);
    por_evt = (src == 0);
    int_rst_evt = (src == 1);
    force_debug_reset_bit = (src == 2);
    tick;
    {por_evt, int_rst_evt, force_debug_reset_bit} = 3'h0;
    run_out(n);
    chk(n, 66);
    settle(cause, bg);
  endtask
  task automatic t_sources;
    do_reset(0, 1'b0, 4'h1, 1'b0);
    do_reset(0, 1'b1, 4'h1, 1'b1);
    do_reset(1, 1'b1, 4'h4, 1'b0);
    do_reset(2, 1'b1, 4'h8, 1'b1);
    do_reset(2, 1'b0, 4'h8, 1'b0);
    $display("t_sources done");
  endtask
  task automatic t_pin;
    rmsp_host_model_inst.hold_ms(1'b1);
    rmsp_host_model_inst.push(6);
    for (int i = 0; i < 20 && internal_reset_ff !== 1'b1; i++) tick;
    run_out(n0);
    settle(4'h2, 1'b0);
    $display("t_pin done");
  endtask
  task automatic t_link;
    logic b;
    for (int k = 0; k < 2; k++) begin
      dbg_tx_bit = !k[0];
      dbg_tx_req = 1'b1;
      tick;
      dbg_tx_req = 1'b0;
      rmsp_host_model_inst.read_bit(b);
      chk(b, !k[0]);
      chk(n_done, k + 1);
      rmsp_host_model_inst.send_bit(k[0]);
      repeat (6) tick;
      chk(rx_got, k[0]);
    end
    $display("t_link done");
  endtask
  initial begin
    repeat (8) tick;
    rst_n = 1'b1;
    run_out(n0);
    t_sources;
    t_pin;
    t_link;
    wrap_up;
  end
endmodule // rmsp_reset_mode_tb_top
bind rmsp_reset_mode rmsp_reset_mode_asserts #(.PORT_W(PORT_W)) rmsp_reset_mode_asserts_inst (.sys_clk, .rst_n,
  .reset_pin_out_ff, .reset_pin_oe_n_ff, .debug_mode_select_pin_out_ff, .debug_mode_select_pin_oe_n_ff,
  .dbg_tx_done_ff, .dbg_rx_valid_ff, .internal_reset_ff, .reset_cause_reg_ff, .background_debug_state_ff,
  .cpu_suspend_ff, .clk_sel_ext_ff, .port_dir_out_ff, .port_pullup_en_ff);
`default_nettype wire
